// [core/irq_prio_regs.vh]
// constants for the peripheral interrupt priority selection block
// assumes an axi4-lite register slave with 32-bit data, one word per register
`ifndef IRQ_PRIO_REGS_VH
`define IRQ_PRIO_REGS_VH

// ---------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------
`define PRIO_SEL_A_OFS     4'h0   // peripheral_priority_select_a
`define PRIO_SEL_B_OFS     4'h4   // peripheral_priority_select_b
`define PRIO_CTRL_OFS      4'h8   // global_priority_enable in bit 0
`define PRIO_STATUS_OFS    4'hC   // effective levels, read only

// ---------------------------------------------------------------------
// implemented bits and reset values
// ---------------------------------------------------------------------
`define PRIO_SEL_A_MASK    8'h77  // bits 6,5,4,2,1,0
`define PRIO_SEL_B_MASK    8'h96  // bits 7,4,2,1
`define PRIO_SEL_A_RST     8'h77  // all implemented bits high priority
`define PRIO_SEL_B_RST     8'h96  // all implemented bits high priority
`define PRIO_CTRL_RST      1'h0   // priority levels off after reset

// ---------------------------------------------------------------------
// field positions, register a
// ---------------------------------------------------------------------
`define CONVERTER_BIT      6
`define SERIAL_RX_BIT      5
`define SERIAL_TX_BIT      4
`define CAPTURE_CMP_BIT    2
`define TIMER2_MATCH_BIT   1
`define TIMER1_OVF_BIT     0

// ---------------------------------------------------------------------
// field positions, register b
// ---------------------------------------------------------------------
`define OSC_FAIL_BIT       7
`define NVM_WRITE_BIT      4
`define SUPPLY_DETECT_BIT  2
`define TIMER3_OVF_BIT     1

// ---------------------------------------------------------------------
// bus responses
// ---------------------------------------------------------------------
`define AXI_RESP_OKAY      2'h0
`define AXI_RESP_SLVERR    2'h2

`endif

// [core/prio_level_map.v]
// maps stored priority selections to the effective per-source levels
// assumes the two select registers already hold only implemented bits
`timescale 1ns/1ps
`include "irq_prio_regs.vh"

module prio_level_map (
  input  wire       i_core_clk,                 // system clock
  input  wire       i_rst,                      // sync reset, active high
  input  wire       i_enable,                   // global_priority_enable
  input  wire [7:0] i_sel_a,                    // peripheral_priority_select_a
  input  wire [7:0] i_sel_b,                    // peripheral_priority_select_b
  output reg  [5:0] o_level_a,                  // effective levels, register a sources
  output reg  [3:0] o_level_b                   // effective levels, register b sources
);

  // ---------------------------------------------------------------------
  // level registers
  // ---------------------------------------------------------------------
  // with priorities off every source sits on the one shared level (high)
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_level_a <= 6'h3F;                       // reset: single level
      o_level_b <= 4'hF;
    end else if (i_enable) begin
      o_level_a <= {i_sel_a[`CONVERTER_BIT],
                    i_sel_a[`SERIAL_RX_BIT],
                    i_sel_a[`SERIAL_TX_BIT],
                    i_sel_a[`CAPTURE_CMP_BIT],
                    i_sel_a[`TIMER2_MATCH_BIT],
                    i_sel_a[`TIMER1_OVF_BIT]};
      o_level_b <= {i_sel_b[`OSC_FAIL_BIT],
                    i_sel_b[`NVM_WRITE_BIT],
                    i_sel_b[`SUPPLY_DETECT_BIT],
                    i_sel_b[`TIMER3_OVF_BIT]};
    end else begin
      o_level_a <= 6'h3F;                       // legacy mode
      o_level_b <= 4'hF;
    end
  end

endmodule // prio_level_map

// [core/peripheral_irq_priority_select.v]
// peripheral interrupt priority selection registers with axi4-lite access
// assumes a single clock, sync reset, and the vectoring logic downstream
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "irq_prio_regs.vh"

module peripheral_irq_priority_select #(
  parameter ADDR_W = 4                          // axi address width
) (
  input  wire              i_core_clk,          // system clock, 10 MHz
  input  wire              i_rst,               // sync reset, active high
  // axi4-lite write address
  input  wire [ADDR_W-1:0] i_s_axi_awaddr,      // write address
  input  wire              i_s_axi_awvalid,     // write address valid
  output reg               o_s_axi_awready,     // write address ready
  // axi4-lite write data
  input  wire [31:0]       i_s_axi_wdata,       // write data
  input  wire [3:0]        i_s_axi_wstrb,       // byte strobes
  input  wire              i_s_axi_wvalid,      // write data valid
  output reg               o_s_axi_wready,      // write data ready
  // axi4-lite write response
  output reg  [1:0]        o_s_axi_bresp,       // write response
  output reg               o_s_axi_bvalid,      // write response valid
  input  wire              i_s_axi_bready,      // write response ready
  // axi4-lite read address
  input  wire [ADDR_W-1:0] i_s_axi_araddr,      // read address
  input  wire              i_s_axi_arvalid,     // read address valid
  output reg               o_s_axi_arready,     // read address ready
  // axi4-lite read data
  output reg  [31:0]       o_s_axi_rdata,       // read data
  output reg  [1:0]        o_s_axi_rresp,       // read response
  output reg               o_s_axi_rvalid,      // read data valid
  input  wire              i_s_axi_rready,      // read data ready
  // towards the vectoring logic
  output reg               o_global_priority_enable,   // priority levels on
  output wire              o_converter_irq_level,      // 1 high, 0 low
  output wire              o_serial_rx_irq_level,      // 1 high, 0 low
  output wire              o_serial_tx_irq_level,      // 1 high, 0 low
  output wire              o_capture_compare_irq_level,// 1 high, 0 low
  output wire              o_timer2_match_irq_level,   // 1 high, 0 low
  output wire              o_timer1_overflow_irq_level,// 1 high, 0 low
  output wire              o_osc_fail_irq_level,       // 1 high, 0 low
  output wire              o_nvm_write_irq_level,      // 1 high, 0 low
  output wire              o_supply_detect_irq_level,  // 1 high, 0 low
  output wire              o_timer3_overflow_irq_level // 1 high, 0 low
);

  // ---------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------
  reg  [7:0]        peripheral_priority_select_a; // register a sources
  reg  [7:0]        peripheral_priority_select_b; // register b sources
  reg  [ADDR_W-1:0] aw_addr;                    // held write address
  reg               aw_full;                    // write address held
  reg  [31:0]       w_data;                     // held write data
  reg  [3:0]        w_strb;                     // held strobes
  reg               w_full;                     // write data held
  wire [5:0]        level_a;                    // effective levels a
  wire [3:0]        level_b;                    // effective levels b

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  // one for any address that holds a register
  function mapped;
    input [ADDR_W-1:0] addr;
    begin
      mapped = (addr == `PRIO_SEL_A_OFS) || (addr == `PRIO_SEL_B_OFS) ||
               (addr == `PRIO_CTRL_OFS)  || (addr == `PRIO_STATUS_OFS);
    end
  endfunction

  // read value of one register, zero above the implemented bits
  function [31:0] read_word;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `PRIO_SEL_A_OFS:  read_word = {24'h000000, peripheral_priority_select_a};
        `PRIO_SEL_B_OFS:  read_word = {24'h000000, peripheral_priority_select_b};
        `PRIO_CTRL_OFS:   read_word = {31'h00000000, o_global_priority_enable};
        `PRIO_STATUS_OFS: read_word = {22'h000000, level_b, level_a};
        default:          read_word = 32'h00000000;                               // unmapped
      endcase
    end
  endfunction

  // ---------------------------------------------------------------------
  // write channels: address and data taken in either order
  // ---------------------------------------------------------------------
  // each ready drops once its channel is taken and reopens only when the
  // response is accepted, so a second write can never overwrite held
  // address or data before the register update has used them
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      aw_full         <= 1'b0;
      w_full          <= 1'b0;
      aw_addr         <= {ADDR_W{1'b0}};
      w_data          <= 32'h00000000;
      w_strb          <= 4'h0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin // address taken
        aw_addr         <= i_s_axi_awaddr;
        aw_full         <= 1'b1;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin   // data taken
        w_data         <= i_s_axi_wdata;
        w_strb         <= i_s_axi_wstrb;
        w_full         <= 1'b1;
        o_s_axi_wready <= 1'b0;
      end
      if (aw_full && w_full && !o_s_axi_bvalid) begin // write performed
        aw_full <= 1'b0;
        w_full  <= 1'b0;
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin     // reopen after response
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // register write and write response
  // ---------------------------------------------------------------------
  // only byte lane 0 carries register bits; other lanes are ignored
  // a write without lane 0 to a mapped address is still a legal access and answers okay,
  // it simply carries no register bits
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      peripheral_priority_select_a <= `PRIO_SEL_A_RST;
      peripheral_priority_select_b <= `PRIO_SEL_B_RST;
      o_global_priority_enable     <= `PRIO_CTRL_RST;
      o_s_axi_bvalid               <= 1'b0;
      o_s_axi_bresp                <= `AXI_RESP_OKAY;
    end else begin
      if (aw_full && w_full && !o_s_axi_bvalid) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= mapped(aw_addr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        if (w_strb[0]) begin
          case (aw_addr)
            `PRIO_SEL_A_OFS: begin
              peripheral_priority_select_a <= w_data[7:0] & `PRIO_SEL_A_MASK;
            end
            `PRIO_SEL_B_OFS: begin
              peripheral_priority_select_b <= w_data[7:0] & `PRIO_SEL_B_MASK;
            end
            `PRIO_CTRL_OFS: begin               // global enable
              o_global_priority_enable <= w_data[0];
            end
            default: begin                      // status and unmapped: no effect
            end
          endcase
        end
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;                 // response accepted
      end
    end
  end

  // ---------------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------------
  // read data is captured when the address is taken and then held, so a
  // master that is slow with rready never sees the word change under it;
  // a write landing meanwhile shows up on the next read
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h00000000;
      o_s_axi_rresp   <= `AXI_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin // address taken
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rdata   <= read_word(i_s_axi_araddr);
      o_s_axi_rresp   <= mapped(i_s_axi_araddr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin   // data accepted
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // effective levels towards the vectoring logic
  // ---------------------------------------------------------------------
  prio_level_map u_level_map (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_enable   (o_global_priority_enable),
    .i_sel_a    (peripheral_priority_select_a),
    .i_sel_b    (peripheral_priority_select_b),
    .o_level_a  (level_a),
    .o_level_b  (level_b)
  );

  // levels lag a select or enable write by one clock; the vectoring logic
  // sees the old level for that one cycle
  // level outputs straight from the map's flip-flops
  assign o_converter_irq_level       = level_a[5];
  assign o_serial_rx_irq_level       = level_a[4];
  assign o_serial_tx_irq_level       = level_a[3];
  assign o_capture_compare_irq_level = level_a[2];
  assign o_timer2_match_irq_level    = level_a[1];
  assign o_timer1_overflow_irq_level = level_a[0];
  assign o_osc_fail_irq_level        = level_b[3];
  assign o_nvm_write_irq_level       = level_b[2];
  assign o_supply_detect_irq_level   = level_b[1];
  assign o_timer3_overflow_irq_level = level_b[0];

endmodule // peripheral_irq_priority_select

// [verif/prio_sel_assertions.sv]
// bus handshake and level-output checks for the priority selection block
// assumes it is bound to the top module and sees only that module's ports
`timescale 1ns/1ps

module prio_sel_assertions (
  input wire logic        i_core_clk,                // system clock
  input wire logic        i_rst,                     // sync reset
  input wire logic        i_s_axi_awvalid,           // write address valid
  input wire logic        o_s_axi_awready,           // write address ready
  input wire logic        i_s_axi_wvalid,            // write data valid
  input wire logic        o_s_axi_wready,            // write data ready
  input wire logic        o_s_axi_bvalid,            // write response valid
  input wire logic        i_s_axi_bready,            // write response ready
  input wire logic [1:0]  o_s_axi_bresp,             // write response
  input wire logic        i_s_axi_arvalid,           // read address valid
  input wire logic        o_s_axi_arready,           // read address ready
  input wire logic        o_s_axi_rvalid,            // read data valid
  input wire logic        i_s_axi_rready,            // read data ready
  input wire logic [31:0] o_s_axi_rdata,             // read data
  input wire logic [1:0]  o_s_axi_rresp,             // read response
  input wire logic        o_global_priority_enable,  // priority levels on
  input wire logic        o_converter_irq_level,     // converter level
  input wire logic        o_supply_detect_irq_level  // supply detect level
);
  // -------------------------------------------------------------------
  // properties
  // -------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_legacy_all_high: assert property (!o_global_priority_enable && !$past(o_global_priority_enable) |->
    o_converter_irq_level && o_supply_detect_irq_level) else $error("level low while priority off");
  a_level_cause: assert property ($changed(o_converter_irq_level) || $changed(o_supply_detect_irq_level)
    |-> $past(o_s_axi_bvalid)) else $error("level moved without a write");
  a_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready |->
    ##2 o_s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read data late");
  a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read data dropped");
  a_write_blocked: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write accepted while response pending");
  a_read_blocked: assert property (o_s_axi_rvalid |-> !o_s_axi_arready) else $error("read accepted while busy");
  a_error_zero: assert property (o_s_axi_rvalid && o_s_axi_rresp != 2'h0 |-> o_s_axi_rdata == 32'h0)
    else $error("error read returned data");
endmodule // prio_sel_assertions

bind peripheral_irq_priority_select prio_sel_assertions u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid),
  .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
  .o_s_axi_bresp(o_s_axi_bresp), .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready), .o_s_axi_rdata(o_s_axi_rdata),
  .o_s_axi_rresp(o_s_axi_rresp), .o_global_priority_enable(o_global_priority_enable),
  .o_converter_irq_level(o_converter_irq_level), .o_supply_detect_irq_level(o_supply_detect_irq_level));

// [verif/prio_vector_sink.sv]
// model of the vectoring logic that consumes the effective levels
// assumes levels are registered outputs of the block, same clock
`timescale 1ns/1ps

module prio_vector_sink (
  input  wire logic        i_core_clk,  // system clock
  input  wire logic        i_rst,       // sync reset
  input  wire logic        i_enable,    // global_priority_enable
  input  wire logic [9:0]  i_levels,    // effective levels, status order
  output logic      [10:0] o_seen       // {enable, levels} as captured
);
  // capture what the vectoring logic would act on each cycle
  always @(posedge i_core_clk) begin
    o_seen <= i_rst ? 11'h3FF : {i_enable, i_levels};
  end
endmodule // prio_vector_sink

// [verif/tb.sv]
// register-level test of the priority selection block
// assumes a 10 MHz clock and an axi4-lite master driven from here
`timescale 1ns/1ps

module tb;
  logic        i_core_clk = 0;                            // clock
  logic        i_rst = 1;                                 // reset
  logic [3:0]  awaddr = 0, araddr = 0, wstrb = 0;         // bus requests
  logic [31:0] wdata = 0;                                 // write data
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire         awready, wready, bvalid, arready, rvalid, en;
  wire  [1:0]  bresp, rresp;                              // responses
  wire  [31:0] rdata;                                     // read data
  wire  [9:0]  lv;                                        // levels
  wire  [10:0] seen;                                      // sink capture
  int          fail_count = 0, tests_run = 0, i;
  int          abit[6] = '{0, 1, 2, 4, 5, 6};             // register a fields
  int          bbit[4] = '{1, 2, 4, 7};                   // register b fields

  always #50 i_core_clk = ~i_core_clk;

  peripheral_irq_priority_select DUT (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_global_priority_enable(en), .o_converter_irq_level(lv[5]), .o_serial_rx_irq_level(lv[4]),
    .o_serial_tx_irq_level(lv[3]), .o_capture_compare_irq_level(lv[2]), .o_timer2_match_irq_level(lv[1]),
    .o_timer1_overflow_irq_level(lv[0]), .o_osc_fail_irq_level(lv[9]), .o_nvm_write_irq_level(lv[8]),
    .o_supply_detect_irq_level(lv[7]), .o_timer3_overflow_irq_level(lv[6]));
  prio_vector_sink u_sink (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_enable(en), .i_levels(lv), .o_seen(seen));

  // -------------------------------------------------------------------
  // checking and bus tasks
  // -------------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait ran out
  task automatic hang;
    fail_count++;
    $display("CHECK FAILED at %0t: bus wait timed out", $time);
    final_report;
  endtask

  // one write; ready sampled at the falling edge before the taking edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    bit ad, wd, ak, wk, got;
    logic [1:0] r;
    n = 0; ad = 0; wd = 0; got = 0;
    @(posedge i_core_clk);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(ad && wd)) begin
      @(negedge i_core_clk);
      ak = awvalid && awready; wk = wvalid && wready;
      @(posedge i_core_clk);
      if (ak) awvalid <= 0;
      if (wk) wvalid <= 0;
      ad |= ak; wd |= wk;
      if (++n > 50) hang;
    end
    while (!got) begin
      @(negedge i_core_clk);
      got = bvalid; r = bresp;
      @(posedge i_core_clk);
      if (++n > 100) hang;
    end
    bready <= 0;
    chk({30'h0, r}, {30'h0, er});
  endtask

  // one read with expected data and response
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    bit got, ak;
    logic [31:0] d;
    logic [1:0] r;
    n = 0; got = 0;
    @(posedge i_core_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!got) begin
      @(negedge i_core_clk);
      ak = arvalid && arready;
      got = rvalid; d = rdata; r = rresp;
      @(posedge i_core_clk);
      if (ak) arvalid <= 0;                         // release only at the taking edge
      if (++n > 50) hang;
    end
    arvalid <= 0; rready <= 0;
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_rst <= 0;
    rd(4'h0, 32'h77, 2'h0);
    rd(4'h4, 32'h96, 2'h0);
    rd(4'h8, 32'h0, 2'h0);
    wr(4'h0, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(4'h0, 32'h77, 2'h0);
    wr(4'h0, 32'h0, 4'hF, 2'h0);
    wr(4'h4, 32'h0, 4'hF, 2'h0);
    rd(4'hC, 32'h3FF, 2'h0);
    chk({21'h0, seen}, 32'h3FF);
    wr(4'h8, 32'h1, 4'hF, 2'h0);
    for (i = 0; i < 10; i++) begin
      wr(4'h0, i < 6 ? 32'(1 << abit[i]) : 32'h0, 4'hF, 2'h0);
      wr(4'h4, i > 5 ? 32'(1 << bbit[i - 6]) : 32'h0, 4'hF, 2'h0);
      rd(4'hC, 32'(1 << i), 2'h0);
      chk({21'h0, seen}, 32'h400 | 32'(1 << i));
    end
    wr(4'h8, 32'h0, 4'hF, 2'h0);
    rd(4'hC, 32'h3FF, 2'h0);
    chk({21'h0, seen}, 32'h3FF);
    wr(4'h0, 32'h77, 4'hE, 2'h0);
    rd(4'h0, 32'h0, 2'h0);
    wr(4'h1, 32'hFF, 4'hF, 2'h2);
    rd(4'h1, 32'h0, 2'h2);
    rd(4'h0, 32'h0, 2'h0);
    // priorities on with only the oscillator source high, then a mid-run reset
    wr(4'h8, 32'h1, 4'hF, 2'h0);
    rd(4'hC, 32'h200, 2'h0);
    i_rst <= 1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 0;
    rd(4'h0, 32'h77, 2'h0);
    rd(4'h4, 32'h96, 2'h0);
    rd(4'h8, 32'h0, 2'h0);
    rd(4'hC, 32'h3FF, 2'h0);
    chk({21'h0, seen}, 32'h3FF);
    final_report;
  end
endmodule // tb
